// [src/boot_start_sequencer.sv]
// Purpose : Power-on and start-switch boot sequencer with clear pulses
// Assumes : Processor read strobe and memory data are on CLK_SYS
// Notes   : Switch and strap pins are synchronised before use
//
// How it works
// - Power-up and start-switch release both force a jump to the switch address.
// - Boot target low byte is always zero, a 256-byte boundary.
// - Eight switches form address bits 15..8, lowest switch is bit 8.
// - With the monitor fitted, the boot high byte is forced to FD hex.
// - Default scheme: clear pulse at power-up, never an auxiliary clear.
// - Config selects normal or one of four alternate pulse schemes.
// - Auxiliary clear pulse is driven out for peripheral boards.
// - Forced bytes: jump opcode, low byte zero, then switch high byte.
`timescale 1ns/100ps

module boot_start_sequencer
  import boot_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] PCLR_CYCLES = PCLR_CYC,
  parameter logic [CNT_W-1:0] AUX_CYCLES = AUX_CYC
) (
  // Clock, reset, enable
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Board pins
  input  wire logic [7:0]  BOOT_SW,
  input  wire logic        START_SW,
  input  wire logic        MONITOR_FITTED,
  // Processor read path
  input  wire logic        CPU_RD_STB,
  input  wire logic [7:0]  MEM_RDATA,
  output logic      [7:0]  CPU_RDATA,
  output logic             CPU_RVALID,
  // Clear pulses and status
  output logic             POWER_ON_CLEAR_PULSE,
  output logic             AUXILIARY_CLEAR_PULSE,
  output logic             START_ACTIVE
);

  // ----------------------------------------------------------------
  // Scheme decode
  // ----------------------------------------------------------------
  function automatic logic pclr_on(input logic [2:0] sch, input logic on_start);
    if (!on_start) begin
      pclr_on = 1'b1;
    end else begin
      pclr_on = (sch == SCH_ALT2) || (sch == SCH_ALT3);
    end
  endfunction

  function automatic logic aux_on(input logic [2:0] sch, input logic on_start);
    if (!on_start) begin
      aux_on = (sch == SCH_ALT1) || (sch == SCH_ALT3) || (sch == SCH_ALT4);
    end else begin
      aux_on = (sch == SCH_ALT1) || (sch == SCH_ALT3);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       sw_s1_q,  sw_s1_d,  sw_s2_q,  sw_s2_d;
  logic             st_s1_q,  st_s1_d,  st_s2_q,  st_s2_d,  st_s3_q,  st_s3_d;
  logic             mon_s1_q, mon_s1_d, mon_s2_q, mon_s2_d;
  logic             pwr_pend_q, pwr_pend_d;
  logic [CNT_W-1:0] pclr_cnt_q, pclr_cnt_d, aux_cnt_q, aux_cnt_d;
  seq_state_t       seq_q, seq_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             rvalid_q, rvalid_d;
  logic             pclr_q, pclr_d, aux_q, aux_d, act_q, act_d;
  logic [2:0]       cfg_q, cfg_d;
  logic             wr_pend_q, wr_pend_d;
  logic [7:0]       wr_addr_q, wr_addr_d;
  logic [31:0]      hrdata_q, hrdata_d;
  logic             hready_q, hresp_q;
  logic [7:0]       boot_hi;
  logic             ev_pwr, ev_start, ev, on_start, addr_ph;
  status_t          stat;

  always_comb begin
    // Pin synchronisers; logic reads the second stage, and the third as well for the start switch
    sw_s1_d  = BOOT_SW;
    sw_s2_d  = sw_s1_q;
    st_s1_d  = START_SW;
    st_s2_d  = st_s1_q;
    st_s3_d  = st_s2_q;
    mon_s1_d = MONITOR_FITTED;
    mon_s2_d = mon_s1_q;

    boot_hi  = mon_s2_q ? MONITOR_HI : sw_s2_q;

    // Power-up counts as the first event after reset release
    ev_pwr     = pwr_pend_q;
    ev_start   = st_s3_q && !st_s2_q;             // Switch release
    ev         = ev_pwr || ev_start;
    on_start   = !ev_pwr;
    pwr_pend_d = 1'b0;

    // Clear pulse counters, retriggered by each event that the scheme selects for them
    pclr_cnt_d = (pclr_cnt_q != CNT_ZERO) ? pclr_cnt_q - CNT_ONE : CNT_ZERO;
    aux_cnt_d = (aux_cnt_q != CNT_ZERO) ? aux_cnt_q - CNT_ONE : CNT_ZERO;
    if (ev && pclr_on(cfg_q, on_start)) begin
      pclr_cnt_d = PCLR_CYCLES;
    end
    if (ev && aux_on(cfg_q, on_start)) begin
      aux_cnt_d = AUX_CYCLES;
    end
    pclr_d = (pclr_cnt_d != CNT_ZERO);
    aux_d = (aux_cnt_d != CNT_ZERO);

    // Forced start bytes; a new event restarts the sequence
    seq_d    = seq_q;
    rvalid_d = CPU_RD_STB;
    rdata_d  = rdata_q;
    if (CPU_RD_STB) begin
      case (seq_q)
        SQ_OPCODE: begin
          rdata_d = JUMP_OPCODE;
          seq_d   = SQ_ADDR_LO;
        end
        SQ_ADDR_LO: begin
          rdata_d = BOOT_LO;
          seq_d   = SQ_ADDR_HI;
        end
        SQ_ADDR_HI: begin
          rdata_d = boot_hi;
          seq_d   = SQ_IDLE;
        end
        default: begin
          rdata_d = MEM_RDATA;
        end
      endcase
    end
    if (ev) begin
      seq_d = SQ_OPCODE;
    end
    act_d = (seq_d != SQ_IDLE);

    // AHB-Lite: zero-wait slave, read data registered in address phase
    stat.boot_hi = boot_hi;
    stat.aux     = aux_q;
    stat.pclr    = pclr_q;
    stat.active  = act_q;
    stat.state   = seq_q;
    addr_ph   = HSEL && HTRANS[1] && HREADY;
    wr_pend_d = addr_ph && HWRITE;
    wr_addr_d = HADDR[REG_AW-1:0];
    hrdata_d  = hrdata_q;
    cfg_d     = cfg_q;
    if (wr_pend_q && (wr_addr_q == REG_CONFIG)) begin
      cfg_d = HWDATA[CFG_SCH_LSB +: CFG_SCH_W];
    end
    if (addr_ph && !HWRITE) begin
      case (HADDR[REG_AW-1:0])
        REG_CONFIG: hrdata_d = {{(32-CFG_SCH_W){1'b0}}, cfg_q};
        REG_STATUS: hrdata_d = {{(32-STAT_W){1'b0}}, stat};
        default:    hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sw_s1_q    <= 8'h00;
      sw_s2_q    <= 8'h00;
      st_s1_q    <= 1'b0;
      st_s2_q    <= 1'b0;
      st_s3_q    <= 1'b0;
      mon_s1_q   <= 1'b0;
      mon_s2_q   <= 1'b0;
      pwr_pend_q <= 1'b1;
      pclr_cnt_q <= CNT_ZERO;
      aux_cnt_q  <= CNT_ZERO;
      pclr_q     <= 1'b0;
      aux_q      <= 1'b0;
      seq_q      <= SQ_IDLE;
      act_q      <= 1'b0;
      rdata_q    <= 8'h00;
      rvalid_q   <= 1'b0;
      cfg_q      <= CFG_RESET;
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      hrdata_q   <= 32'h00000000;
      hready_q   <= 1'b1;
      hresp_q    <= 1'b0;
    end else if (CE) begin
      sw_s1_q    <= sw_s1_d;
      sw_s2_q    <= sw_s2_d;
      st_s1_q    <= st_s1_d;
      st_s2_q    <= st_s2_d;
      st_s3_q    <= st_s3_d;
      mon_s1_q   <= mon_s1_d;
      mon_s2_q   <= mon_s2_d;
      pwr_pend_q <= pwr_pend_d;
      pclr_cnt_q <= pclr_cnt_d;
      aux_cnt_q  <= aux_cnt_d;
      pclr_q     <= pclr_d;
      aux_q      <= aux_d;
      seq_q      <= seq_d;
      act_q      <= act_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      cfg_q      <= cfg_d;
      wr_pend_q  <= wr_pend_d;
      wr_addr_q  <= wr_addr_d;
      hrdata_q   <= hrdata_d;
      hready_q   <= 1'b1;
      hresp_q    <= 1'b0;
    end
  end

  assign HRDATA                = hrdata_q;
  assign HREADYOUT             = hready_q;
  assign HRESP                 = hresp_q;
  assign CPU_RDATA             = rdata_q;
  assign CPU_RVALID            = rvalid_q;
  assign POWER_ON_CLEAR_PULSE  = pclr_q;
  assign AUXILIARY_CLEAR_PULSE = aux_q;
  assign START_ACTIVE          = act_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_event_restart: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    ev |=> (seq_q == SQ_OPCODE) && START_ACTIVE)
    else $error("event did not restart forced sequence");

  a_opcode_byte: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (CPU_RD_STB && seq_q == SQ_OPCODE) |=> CPU_RVALID && (CPU_RDATA == JUMP_OPCODE))
    else $error("first forced byte is not the jump opcode");

  a_low_byte: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (CPU_RD_STB && seq_q == SQ_ADDR_LO) |=> (CPU_RDATA == BOOT_LO))
    else $error("second forced byte is not zero");

  a_high_byte: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (CPU_RD_STB && seq_q == SQ_ADDR_HI) |=> (CPU_RDATA == $past(boot_hi)))
    else $error("third forced byte is not the switch value");

  a_monitor_addr: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (mon_s2_q && CPU_RD_STB && seq_q == SQ_ADDR_HI) |=> (CPU_RDATA == MONITOR_HI))
    else $error("monitor boot byte wrong");

  a_mem_resume: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (CPU_RD_STB && seq_q == SQ_ADDR_HI && !ev) ##1 (CPU_RD_STB && !ev)
      |=> (CPU_RDATA == $past(MEM_RDATA)) && !START_ACTIVE)
    else $error("memory data did not resume after third byte");

  a_pclr_width: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (ev && pclr_on(cfg_q, on_start)) |=> POWER_ON_CLEAR_PULSE [*8])
    else $error("clear pulse too short");

  a_aux_absent: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (ev && !aux_on(cfg_q, on_start) && aux_cnt_q == CNT_ZERO) |=> !AUXILIARY_CLEAR_PULSE)
    else $error("auxiliary clear emitted when not selected");

  a_aux_driven: assert property (@(posedge CLK_SYS) disable iff (RST || !CE)
    (ev && aux_on(cfg_q, on_start)) |=> AUXILIARY_CLEAR_PULSE [*4])
    else $error("auxiliary clear not driven");

endmodule

// [src/boot_seq_pkg.sv]
// Purpose : Shared constants and types for the boot start sequencer
// Assumes : 100 MHz system clock, 32-bit AHB-Lite register bus
// Notes   : Pulse widths are counted in system clock cycles
package boot_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PCLR_TIME_NS  = 1000;
  localparam int AUX_TIME_NS   = 1000;
  localparam int CNT_W         = 16;
  // Least times, rounded up to whole cycles
  localparam logic [CNT_W-1:0] PCLR_CYC =
    CNT_W'((PCLR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] AUX_CYC =
    CNT_W'((AUX_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Forced start bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] JUMP_OPCODE = 8'hC3;
  localparam logic [7:0] BOOT_LO     = 8'h00;
  localparam logic [7:0] MONITOR_HI  = 8'hFD;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         REG_AW       = 8;
  localparam logic [7:0] REG_CONFIG   = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam int         CFG_SCH_LSB  = 0;
  localparam int         CFG_SCH_W    = 3;
  localparam logic [2:0] CFG_RESET    = 3'h0;
  localparam int         STAT_W       = 13;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCH_NORMAL,
    SCH_ALT1,
    SCH_ALT2,
    SCH_ALT3,
    SCH_ALT4
  } scheme_t;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_OPCODE,
    SQ_ADDR_LO,
    SQ_ADDR_HI
  } seq_state_t;

  typedef struct packed {
    logic [7:0] boot_hi;
    logic       aux;
    logic       pclr;
    logic       active;
    logic [1:0] state;
  } status_t;

endpackage

// [tb/cpu_fetch_model.sv]
// Purpose : Processor-side read cycles with memory data for the sequencer
// Assumes : Caller enters the fetch task right after a rising edge
// Notes   : Memory data is inverted once its strobe is gone, never held
`timescale 1ns/100ps

module cpu_fetch_model (
  // Clock
  input  wire logic       clk_sys,
  // Read cycle
  output logic            rd_stb,
  output logic [7:0]      mem_rdata
);
  initial begin
    rd_stb    = 1'b0;
    mem_rdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // Read cycles
  // ----------------------------------------------------------------
  // A gap of zero keeps the strobe up, giving back-to-back reads
  task automatic fetch(input logic [7:0] mem_byte, input int gap);
    rd_stb    <= 1'b1;
    mem_rdata <= mem_byte;
    @(posedge clk_sys);
    if (gap > 0) begin
      rd_stb    <= 1'b0;
      mem_rdata <= ~mem_byte;
      repeat (gap) @(posedge clk_sys);
    end
  endtask

  task automatic stop();
    rd_stb    <= 1'b0;
    mem_rdata <= ~mem_rdata;
    @(posedge clk_sys);
  endtask
endmodule

// [tb/boot_start_sequencer_test.sv]
// Purpose : Self-checking bench for the boot start sequencer
// Assumes : Pulse widths shortened to 10 cycles to keep the run short
// Notes   : Config resets to normal, so alternate schemes use start release only
`timescale 1ns/100ps

module boot_start_sequencer_test;
  import boot_seq_pkg::*;
  localparam logic [CNT_W-1:0] PW = 16'h000A;

  logic        CLK_SYS, RST, CE, HSEL, HWRITE, HREADYOUT, HRESP, START_SW;
  logic [31:0] HADDR, HWDATA, HRDATA, r;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [7:0]  BOOT_SW, MEM_RDATA, CPU_RDATA, sw;
  logic        MONITOR_FITTED, CPU_RD_STB, CPU_RVALID, POWER_ON_CLEAR_PULSE;
  logic        AUXILIARY_CLEAR_PULSE, START_ACTIVE;
  logic [7:0]  exp_q[$];
  int          seed, bad_count, num_checks, pclr_n, aux_n, pclr_w, aux_w, ep, ea;

  boot_start_sequencer #(.PCLR_CYCLES(PW), .AUX_CYCLES(PW)) boot_start_sequencer_i (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .BOOT_SW(BOOT_SW), .START_SW(START_SW), .MONITOR_FITTED(MONITOR_FITTED),
    .CPU_RD_STB(CPU_RD_STB), .MEM_RDATA(MEM_RDATA), .CPU_RDATA(CPU_RDATA),
    .CPU_RVALID(CPU_RVALID), .POWER_ON_CLEAR_PULSE(POWER_ON_CLEAR_PULSE),
    .AUXILIARY_CLEAR_PULSE(AUXILIARY_CLEAR_PULSE), .START_ACTIVE(START_ACTIVE));

  cpu_fetch_model cpu_fetch_model_i (
    .clk_sys(CLK_SYS), .rd_stb(CPU_RD_STB), .mem_rdata(MEM_RDATA));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // Hang guard: whole run needs well under 2000 cycles
  initial begin
    repeat (4000) @(posedge CLK_SYS);
    bad_count++;
    final_report();
  end

  // Oldest noted byte against each answered read; pulse widths on each fall
  always @(posedge CLK_SYS) begin
    if (CPU_RVALID === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected_read", 32'h1, 32'h0);
      else check("cpu_rdata", {24'h0, CPU_RDATA}, {24'h0, exp_q.pop_front()});
    end
    if (POWER_ON_CLEAR_PULSE === 1'b1) pclr_w++;
    else if (pclr_w != 0) begin
      check("pclr_width", 32'(pclr_w), 32'(PW));
      pclr_n++;
      pclr_w = 0;
    end
    if (AUXILIARY_CLEAR_PULSE === 1'b1) aux_w++;
    else if (aux_w != 0) begin
      check("aux_width", 32'(aux_w), 32'(PW));
      aux_n++;
      aux_w = 0;
    end
  end

  // ----------------------------------------------------------------
  // Bus, switch and boot tasks
  // ----------------------------------------------------------------
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= a;
    HWRITE <= w;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
    r = HRDATA;
    check("hresp", {31'h0, HRESP}, 32'h0);
  endtask

  task automatic press();
    START_SW <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    START_SW <= 1'b0;
  endtask

  // Four reads: three forced bytes, then plain memory data
  task automatic boot(input logic [7:0] hi);
    int n;
    logic [7:0] m;
    n = 0;
    while (START_ACTIVE !== 1'b1 && n < 40) begin
      @(posedge CLK_SYS);
      n++;
    end
    check("start_active", {31'h0, START_ACTIVE}, 32'h1);
    m = 8'($random(seed));
    exp_q.push_back(JUMP_OPCODE);
    exp_q.push_back(BOOT_LO);
    exp_q.push_back(hi);
    exp_q.push_back(m);
    cpu_fetch_model_i.fetch(JUMP_OPCODE ^ 8'hFF, $random(seed) & 1);
    cpu_fetch_model_i.fetch(8'h5A, $random(seed) & 1);
    cpu_fetch_model_i.fetch(8'hA5, $random(seed) & 1);
    cpu_fetch_model_i.fetch(m, 1);
    cpu_fetch_model_i.stop();
    repeat (PW + 8) @(posedge CLK_SYS);
    check("reads_left", 32'(exp_q.size()), 32'h0);
    check("start_done", {31'h0, START_ACTIVE}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 54;
    {bad_count, num_checks, pclr_n, aux_n, pclr_w, aux_w} = '0;
    {RST, CE, HSEL, HADDR, HTRANS, HWRITE, HSIZE, HWDATA} = {2'b11, 36'h0, 3'h2, 32'h0};
    START_SW       = 1'b0;
    MONITOR_FITTED = 1'b0;
    sw             = 8'($random(seed));
    BOOT_SW        = sw;
    repeat (12) @(posedge CLK_SYS);
    RST <= 1'b0;
    boot(sw);
    ep = 1;
    ea = 0;
    check("pclr_power", 32'(pclr_n), 32'(ep));
    check("aux_power", 32'(aux_n), 32'(ea));
    ahb(1'b0, {24'h0, REG_CONFIG}, 32'h0);
    check("config_reset", r, 32'h0);
    ahb(1'b0, 32'h0000_0040, 32'h0);
    check("unmapped", r, 32'h0);
    for (int s = 0; s < 5; s++) begin
      sw = 8'($random(seed));
      BOOT_SW <= sw;
      ahb(1'b1, {24'h0, REG_CONFIG}, 32'(s));
      @(posedge CLK_SYS);
      ahb(1'b0, {24'h0, REG_CONFIG}, 32'h0);
      check("config_rd", r, 32'(s));
      press();
      boot(sw);
      ep += (s == 2 || s == 3) ? 1 : 0;
      ea += (s == 1 || s == 3) ? 1 : 0;
      check("pclr_start", 32'(pclr_n), 32'(ep));
      check("aux_start", 32'(aux_n), 32'(ea));
    end
    // Mid-run reset acts as a fresh power-up and returns config to normal
    RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    boot(sw);
    ep += 1;
    check("pclr_reset", 32'(pclr_n), 32'(ep));
    check("aux_reset", 32'(aux_n), 32'(ea));
    ahb(1'b0, {24'h0, REG_CONFIG}, 32'h0);
    check("config_rst", r, 32'h0);
    // Monitor strap overrides the switches
    MONITOR_FITTED <= 1'b1;
    press();
    boot(MONITOR_HI);
    final_report();
  end
endmodule
